// File: hdl/prm_route_top.sv
// Peripheral pin route multiplexer: route registers on AHB-Lite and the pin crossbar.
// Assumes peripheral signals on SYS_CLK; pin levels asynchronous.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module prm_route_top #(
    parameter int ADDR_W = 12,
    parameter int PIN_N = prm_pkg::PRM_PIN_N
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire prm_pkg::prm_periph_t PERIPH_IN,
    output prm_pkg::prm_return_t PERIPH_RET,
    input wire logic [PIN_N-1:0] PIN_IN,
    output logic [PIN_N-1:0] PIN_OUT,
    output logic [PIN_N-1:0] PIN_OE_B
);
    prm_pkg::prm_route_t route_reg, route_next;
    prm_pkg::prm_return_t ret_reg, ret_next;
    logic [PIN_N-1:0] pin_out_reg, pin_out_next;
    logic [PIN_N-1:0] pin_oe_b_reg, pin_oe_b_next;
    logic [PIN_N-1:0] pin_drv;
    logic [PIN_N-1:0] pin_in_s;
    logic wr_stb;
    logic [3:0] wr_idx;
    logic [7:0] wr_data;
    logic [3:0] rd_idx;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave and pin synchroniser
    prm_ahb_slave #(.ADDR_W(ADDR_W)) u_bus (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .hsel(HSEL),
        .haddr(HADDR),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hready(HREADY),
        .hwdata(HWDATA),
        .hreadyout(HREADYOUT),
        .hrdata(HRDATA),
        .hresp(HRESP),
        .wr_stb(wr_stb),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .rd_idx(rd_idx),
        .rd_word(rd_word)
    );

    prm_sync #(.W(PIN_N)) u_sync (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .d(PIN_IN),
        .q(pin_in_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Route registers
    always_comb begin
        route_next = route_reg;
        if (wr_stb) begin
            case (wr_idx)
                prm_pkg::PRM_IDX_SPI: begin
                    route_next.spi[0] = wr_data[prm_pkg::PRM_UNIT0_LSB +: 2];
                    route_next.spi[1] = wr_data[prm_pkg::PRM_UNIT1_LSB +: 2];
                end
                prm_pkg::PRM_IDX_TWI: begin
                    route_next.twi[0] = wr_data[prm_pkg::PRM_UNIT0_LSB +: 2];
                    route_next.twi[1] = wr_data[prm_pkg::PRM_UNIT1_LSB +: 2];
                end
                prm_pkg::PRM_IDX_WT: begin
                    route_next.wt[0] = wr_data[prm_pkg::PRM_WT0_LSB +: 3];
                    route_next.wt[1] = wr_data[prm_pkg::PRM_WT1_LSB +: 3];
                end
                prm_pkg::PRM_IDX_CT: route_next.ct = wr_data[prm_pkg::PRM_BIT_LSB +: 5];
                prm_pkg::PRM_IDX_DT: route_next.dt = wr_data[prm_pkg::PRM_BIT_LSB +: 3];
                prm_pkg::PRM_IDX_CMP: route_next.cmp = wr_data[prm_pkg::PRM_BIT_LSB +: 3];
                prm_pkg::PRM_IDX_ZC: route_next.zc = wr_data[prm_pkg::PRM_BIT_LSB +: 3];
                default: route_next = route_reg;
            endcase
        end
    end

    // Read word includes a write landing in the same cycle
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            prm_pkg::PRM_IDX_SPI: begin
                rd_word[prm_pkg::PRM_UNIT0_LSB +: 2] = route_next.spi[0];
                rd_word[prm_pkg::PRM_UNIT1_LSB +: 2] = route_next.spi[1];
            end
            prm_pkg::PRM_IDX_TWI: begin
                rd_word[prm_pkg::PRM_UNIT0_LSB +: 2] = route_next.twi[0];
                rd_word[prm_pkg::PRM_UNIT1_LSB +: 2] = route_next.twi[1];
            end
            prm_pkg::PRM_IDX_WT: begin
                rd_word[prm_pkg::PRM_WT0_LSB +: 3] = route_next.wt[0];
                rd_word[prm_pkg::PRM_WT1_LSB +: 3] = route_next.wt[1];
            end
            prm_pkg::PRM_IDX_CT: rd_word[prm_pkg::PRM_BIT_LSB +: 5] = route_next.ct;
            prm_pkg::PRM_IDX_DT: rd_word[prm_pkg::PRM_BIT_LSB +: 3] = route_next.dt;
            prm_pkg::PRM_IDX_CMP: rd_word[prm_pkg::PRM_BIT_LSB +: 3] = route_next.cmp;
            prm_pkg::PRM_IDX_ZC: rd_word[prm_pkg::PRM_BIT_LSB +: 3] = route_next.zc;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            route_reg <= prm_pkg::prm_route_t'(prm_pkg::PRM_ROUTE_RESET);
        end else begin
            route_reg <= route_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin crossbar, later sources win a shared pin
    always_comb begin
        int p;
        p = 0;
        pin_out_next = '0;
        pin_drv = '0;
        for (int i = 0; i < 3; i++) begin
            if (PERIPH_IN.zc_en[i]) begin
                p = route_reg.zc[i] ? prm_pkg::PRM_ZC_ALT : prm_pkg::PRM_ZC_DEF;
                pin_out_next[p] = PERIPH_IN.zc_out[i];
                pin_drv[p] = 1'b1;
            end
            if (PERIPH_IN.cmp_en[i]) begin
                p = route_reg.cmp[i] ? prm_pkg::PRM_CMP_ALT : prm_pkg::PRM_CMP_DEF;
                pin_out_next[p] = PERIPH_IN.cmp_out[i];
                pin_drv[p] = 1'b1;
            end
        end
        for (int i = 0; i < 5; i++) begin
            if (PERIPH_IN.ct_en[i]) begin
                p = route_reg.ct[i] ? prm_pkg::PRM_CT_ALT[i] : prm_pkg::PRM_CT_DEF[i];
                pin_out_next[p] = PERIPH_IN.ct_out[i];
                pin_drv[p] = 1'b1;
            end
        end
        for (int k = 0; k < prm_pkg::PRM_WT_OUTS; k++) begin
            if (route_reg.wt[0] != prm_pkg::PRM_WT0_RSVD && PERIPH_IN.wt_en[0][k]) begin
                p = int'({route_reg.wt[0], 3'h0}) + k;
                pin_out_next[p] = PERIPH_IN.wt_out[0][k];
                pin_drv[p] = 1'b1;
            end
        end
        for (int k = 0; k < prm_pkg::PRM_WT_OUTS; k++) begin
            if (route_reg.wt[1] <= prm_pkg::PRM_WT1_LAST && PERIPH_IN.wt_en[1][k]
                && k < prm_pkg::PRM_WT1_CNT[route_reg.wt[1][1:0]]) begin
                p = int'(prm_pkg::PRM_WT1_BASE[route_reg.wt[1][1:0]]) + k;
                pin_out_next[p] = PERIPH_IN.wt_out[1][k];
                pin_drv[p] = 1'b1;
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (route_reg.dt <= prm_pkg::PRM_DT_LAST && PERIPH_IN.dt_en[k]) begin
                p = int'(prm_pkg::PRM_DT_BASE[route_reg.dt[1:0]]) + k;
                pin_out_next[p] = PERIPH_IN.dt_out[k];
                pin_drv[p] = 1'b1;
            end
        end
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 4; k++) begin
                if (route_reg.twi[u] != prm_pkg::PRM_TWI_RSVD && PERIPH_IN.twi_low[u][k]) begin
                    p = (k < 2) ? int'(prm_pkg::PRM_TWI_HOST_BASE[u][route_reg.twi[u]]) + k
                        : int'(prm_pkg::PRM_TWI_DUAL_BASE[u][route_reg.twi[u]]) + k - 2;
                    pin_out_next[p] = 1'b0;
                    pin_drv[p] = 1'b1;
                end
            end
        end
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 4; k++) begin
                if (route_reg.spi[u] != prm_pkg::PRM_SPI_NONE && PERIPH_IN.spi_en[u][k]) begin
                    p = int'(prm_pkg::PRM_SPI_BASE[u][route_reg.spi[u]]) + k;
                    pin_out_next[p] = PERIPH_IN.spi_out[u][k];
                    pin_drv[p] = 1'b1;
                end
            end
        end
        pin_oe_b_next = ~pin_drv;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin levels back to the serial units, idle high when unrouted
    always_comb begin
        ret_next.spi_in = '1;
        ret_next.twi_in = '1;
        for (int u = 0; u < 2; u++) begin
            for (int k = 0; k < 4; k++) begin
                if (route_reg.spi[u] != prm_pkg::PRM_SPI_NONE) begin
                    ret_next.spi_in[u][k] =
                        pin_in_s[int'(prm_pkg::PRM_SPI_BASE[u][route_reg.spi[u]]) + k];
                end
                if (route_reg.twi[u] != prm_pkg::PRM_TWI_RSVD) begin
                    ret_next.twi_in[u][k] = (k < 2)
                        ? pin_in_s[int'(prm_pkg::PRM_TWI_HOST_BASE[u][route_reg.twi[u]]) + k]
                        : pin_in_s[int'(prm_pkg::PRM_TWI_DUAL_BASE[u][route_reg.twi[u]]) + k - 2];
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_out_reg <= '0;
            pin_oe_b_reg <= '1;
            ret_reg <= '1;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_b_reg <= pin_oe_b_next;
            ret_reg <= ret_next;
        end
    end

    assign PIN_OUT = pin_out_reg;
    assign PIN_OE_B = pin_oe_b_reg;
    assign PERIPH_RET = ret_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    spi_unit1_route_none_a: assert property (
        route_reg.spi[1] == prm_pkg::PRM_SPI_NONE |=> PERIPH_RET.spi_in[1] == 4'hF)
        else $error("unrouted serial unit 1 input not idle high");
    spi_unit0_route_alt_a: assert property (
        (route_reg.spi[0] == 2'h1 && PERIPH_IN.spi_en[0][0])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_E]
             && PIN_OUT[prm_pkg::PRM_PORT_E] == $past(PERIPH_IN.spi_out[0][0])))
        else $error("serial unit 0 not on PE0");
    two_wire_unit1_route_pair_a: assert property (
        (route_reg.twi[1] == 2'h2 && PERIPH_IN.twi_low[1][0])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_B + 6'h02] && !PIN_OUT[prm_pkg::PRM_PORT_B + 6'h02]))
        else $error("two-wire unit 1 not pulling PB2 low");
    wt0_port_a: assert property (
        (route_reg.wt[0] == 3'h3 && PERIPH_IN.wt_en[0][0])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_D]
             && PIN_OUT[prm_pkg::PRM_PORT_D] == $past(PERIPH_IN.wt_out[0][0])))
        else $error("wide timer 0 not on PD0");
    wt0_idle_a: assert property (
        route_reg.wt[0] != 3'h3 |=> PIN_OE_B[prm_pkg::PRM_PORT_D])
        else $error("PD0 driven without its route");
    ct4_alt_a: assert property (
        (route_reg.ct[4] && PERIPH_IN.ct_en[4] && route_reg.spi[1] != 2'h1
         && !PERIPH_IN.twi_low[0][2] && route_reg.wt[1] != 3'h1 && route_reg.wt[0] != 3'h2)
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_C + 6'h06]
             && PIN_OUT[prm_pkg::PRM_PORT_C + 6'h06] == $past(PERIPH_IN.ct_out[4])))
        else $error("capture timer 4 not on PC6");
    dt_alternate_two_a: assert property (
        (route_reg.dt == 3'h2 && PERIPH_IN.dt_en[0])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_F]
             && PIN_OUT[prm_pkg::PRM_PORT_F] == $past(PERIPH_IN.dt_out[0])))
        else $error("dead-time output A not on PF0");
    zc_alt_a: assert property (
        (route_reg.zc[2] && PERIPH_IN.zc_en[2] && route_reg.spi[1] != 2'h1
         && !PERIPH_IN.twi_low[0][3])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_C + 6'h07]
             && PIN_OUT[prm_pkg::PRM_PORT_C + 6'h07] == $past(PERIPH_IN.zc_out[2])))
        else $error("zero-cross 2 not on PC7");
    reg_write_a: assert property (
        (wr_stb && wr_idx == prm_pkg::PRM_IDX_CT)
        |=> route_reg.ct == $past(wr_data[4:0]) ##2 HRDATA[31:8] == 24'h0)
        else $error("route write not taken in one cycle");
    rsvd_zero_a: assert property (
        (HSEL && HTRANS[1] && HREADY && !HWRITE && HADDR[5:2] == prm_pkg::PRM_IDX_CT)
        |=> HRDATA[31:5] == 27'h0)
        else $error("unused route bits read non-zero");

    two_wire_unit0_route_pair_a: assert property (
        (route_reg.twi[0] == 2'h1 && PERIPH_IN.twi_low[0][3] && route_reg.spi[1] != 2'h1)
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_C + 6'h07] && !PIN_OUT[prm_pkg::PRM_PORT_C + 6'h07]))
        else $error("two-wire unit 0 not pulling PC7 low");

    wt1_short_a: assert property (
        (route_reg.wt[1] == 3'h2 && PERIPH_IN.wt_en[1][0])
        |=> (PIN_OE_B[prm_pkg::PRM_PORT_E + 6'h07] && !PIN_OE_B[prm_pkg::PRM_PORT_E + 6'h04]
             && PIN_OUT[prm_pkg::PRM_PORT_E + 6'h04] == $past(PERIPH_IN.wt_out[1][0])))
        else $error("wide timer 1 short route wrong on PE4 or PE7");

    ct1_def_a: assert property (
        (!route_reg.ct[1] && PERIPH_IN.ct_en[1] && !PERIPH_IN.wt_en[0][3]
         && !PERIPH_IN.twi_low[0][1])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_A + 6'h03]
             && PIN_OUT[prm_pkg::PRM_PORT_A + 6'h03] == $past(PERIPH_IN.ct_out[1])))
        else $error("capture timer 1 not on PA3");

    cmp2_def_a: assert property (
        (!route_reg.cmp[2] && PERIPH_IN.cmp_en[2] && !PERIPH_IN.dt_en[3]
         && !PERIPH_IN.spi_en[0][3])
        |=> (!PIN_OE_B[prm_pkg::PRM_PORT_A + 6'h07]
             && PIN_OUT[prm_pkg::PRM_PORT_A + 6'h07] == $past(PERIPH_IN.cmp_out[2])))
        else $error("comparator 2 not on PA7");

    twi_rsvd_a: assert property (
        route_reg.twi[1] == prm_pkg::PRM_TWI_RSVD |=> PERIPH_RET.twi_in[1] == 4'hF)
        else $error("reserved two-wire route not idle high");
endmodule : prm_route_top

// File: pkg/prm_pkg.sv
// Constants, tables and carriers for the peripheral pin route block.
// Assumes seven ports of eight pins, pin index = port * 8 + bit.
package prm_pkg;

    localparam int PRM_PIN_N = 56;

    // Register indices; byte address is four times the index
    localparam logic [3:0] PRM_IDX_SPI = 4'h4;
    localparam logic [3:0] PRM_IDX_TWI = 4'h5;
    localparam logic [3:0] PRM_IDX_WT = 4'h6;
    localparam logic [3:0] PRM_IDX_CT = 4'h7;
    localparam logic [3:0] PRM_IDX_DT = 4'h8;
    localparam logic [3:0] PRM_IDX_CMP = 4'h9;
    localparam logic [3:0] PRM_IDX_ZC = 4'hA;
    localparam logic [3:0] PRM_IDX_UNMAPPED = 4'h0;

    // Field positions
    localparam int PRM_UNIT0_LSB = 0;
    localparam int PRM_UNIT1_LSB = 2;
    localparam int PRM_WT0_LSB = 0;
    localparam int PRM_WT1_LSB = 3;
    localparam int PRM_BIT_LSB = 0;

    // Reset values and special codes
    localparam logic [7:0] PRM_ROUTE_RESET = 8'h00;
    localparam logic [1:0] PRM_SPI_NONE = 2'h3;
    localparam logic [1:0] PRM_TWI_RSVD = 2'h3;
    localparam logic [2:0] PRM_WT0_RSVD = 3'h7;
    localparam logic [2:0] PRM_WT1_LAST = 3'h3;
    localparam logic [2:0] PRM_DT_LAST = 3'h3;

    // Port base pins
    localparam logic [5:0] PRM_PORT_A = 6'h00;
    localparam logic [5:0] PRM_PORT_B = 6'h08;
    localparam logic [5:0] PRM_PORT_C = 6'h10;
    localparam logic [5:0] PRM_PORT_D = 6'h18;
    localparam logic [5:0] PRM_PORT_E = 6'h20;
    localparam logic [5:0] PRM_PORT_F = 6'h28;
    localparam logic [5:0] PRM_PORT_G = 6'h30;

    // Pin tables, [unit][code] for the serial units; others by code, by unit or single pins
    localparam logic [5:0] PRM_SPI_BASE [2][3] = '{
        '{PRM_PORT_A + 6'h04, PRM_PORT_E, PRM_PORT_G + 6'h04},
        '{PRM_PORT_C, PRM_PORT_C + 6'h04, PRM_PORT_B + 6'h04}};
    localparam logic [5:0] PRM_TWI_HOST_BASE [2][3] = '{
        '{PRM_PORT_A + 6'h02, PRM_PORT_A + 6'h02, PRM_PORT_C + 6'h02},
        '{PRM_PORT_F + 6'h02, PRM_PORT_F + 6'h02, PRM_PORT_B + 6'h02}};
    localparam logic [5:0] PRM_TWI_DUAL_BASE [2][3] = '{
        '{PRM_PORT_C + 6'h02, PRM_PORT_C + 6'h06, PRM_PORT_C + 6'h06},
        '{PRM_PORT_B + 6'h02, PRM_PORT_B + 6'h06, PRM_PORT_B + 6'h06}};
    localparam logic [5:0] PRM_WT1_BASE [4] = '{PRM_PORT_B, PRM_PORT_C + 6'h04,
        PRM_PORT_E + 6'h04, PRM_PORT_G};
    localparam int PRM_WT1_CNT [4] = '{6, 3, 3, 6};
    localparam int PRM_WT_OUTS = 6;
    localparam logic [5:0] PRM_DT_BASE [4] = '{PRM_PORT_A + 6'h04, PRM_PORT_B + 6'h04,
        PRM_PORT_F, PRM_PORT_G + 6'h04};
    localparam logic [5:0] PRM_CT_DEF [5] = '{PRM_PORT_A + 6'h02, PRM_PORT_A + 6'h03,
        PRM_PORT_C, PRM_PORT_B + 6'h05, PRM_PORT_G + 6'h03};
    localparam logic [5:0] PRM_CT_ALT [5] = '{PRM_PORT_F + 6'h04, PRM_PORT_F + 6'h05,
        PRM_PORT_B + 6'h04, PRM_PORT_C + 6'h01, PRM_PORT_C + 6'h06};
    localparam logic [5:0] PRM_CMP_DEF = PRM_PORT_A + 6'h07;
    localparam logic [5:0] PRM_CMP_ALT = PRM_PORT_C + 6'h06;
    localparam logic [5:0] PRM_ZC_DEF = PRM_PORT_A + 6'h07;
    localparam logic [5:0] PRM_ZC_ALT = PRM_PORT_C + 6'h07;

    typedef struct packed {
        logic [1:0][1:0] spi;
        logic [1:0][1:0] twi;
        logic [1:0][2:0] wt;
        logic [4:0] ct;
        logic [2:0] dt;
        logic [2:0] cmp;
        logic [2:0] zc;
    } prm_route_t;

    // Lines: spi 0 data-out, 1 data-in, 2 clock, 3 select; twi 0/1 host pair, 2/3 dual pair
    typedef struct packed {
        logic [1:0][3:0] spi_out;
        logic [1:0][3:0] spi_en;
        logic [1:0][3:0] twi_low;
        logic [1:0][5:0] wt_out;
        logic [1:0][5:0] wt_en;
        logic [4:0] ct_out;
        logic [4:0] ct_en;
        logic [3:0] dt_out;
        logic [3:0] dt_en;
        logic [2:0] cmp_out;
        logic [2:0] cmp_en;
        logic [2:0] zc_out;
        logic [2:0] zc_en;
    } prm_periph_t;

    typedef struct packed {
        logic [1:0][3:0] spi_in;
        logic [1:0][3:0] twi_in;
    } prm_return_t;

endpackage : prm_pkg

// File: hdl/prm_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module prm_sync #(
    parameter int W = 56
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : prm_sync

// File: hdl/prm_ahb_slave.sv
// AHB-Lite slave front end with zero wait states.
// Assumes single word transfers; read word supplied combinationally by the owner.
`timescale 1ns/1ps
module prm_ahb_slave #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic wr_stb,
    output logic [3:0] wr_idx,
    output logic [7:0] wr_data,
    output logic [3:0] rd_idx,
    input wire logic [31:0] rd_word
);
    logic accept;
    logic mapped;
    logic wr_pend_reg, wr_pend_next;
    logic [3:0] idx_reg, idx_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address phase
    always_comb begin
        accept = hsel && htrans[1] && hready;
        mapped = (haddr[ADDR_W-1:6] == '0) && (haddr[1:0] == 2'h0);
        rd_idx = mapped ? haddr[5:2] : prm_pkg::PRM_IDX_UNMAPPED;
        wr_pend_next = accept && hwrite;
        idx_next = accept ? rd_idx : idx_reg;
        rdata_next = (accept && !hwrite) ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg <= 1'b0;
            idx_reg <= prm_pkg::PRM_IDX_UNMAPPED;
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b1;
        end else begin
            wr_pend_reg <= wr_pend_next;
            idx_reg <= idx_next;
            rdata_reg <= rdata_next;
            ready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data phase
    assign wr_stb = wr_pend_reg;
    assign wr_idx = idx_reg;
    assign wr_data = hwdata[7:0];
    assign hrdata = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;
endmodule : prm_ahb_slave

// File: verification/prm_far_model.sv
// Far side: peripherals driving one group at a time, and the pin wires.
// Assumes the bench picks the group and the drive level.
`timescale 1ns/1ps
module prm_far_model (
    input wire logic [2:0] kind,
    input wire logic lvl,
    input wire logic [55:0] pin_out,
    input wire logic [55:0] pin_oe_b,
    output prm_pkg::prm_periph_t periph,
    output logic [55:0] pin_in
);
    logic [55:0] pat;
    assign pat = {7{8'hA5}} ^ {56{lvl}};
    // Driven pins carry the block's level, others the outside pattern
    assign pin_in = (pin_oe_b & pat) | (~pin_oe_b & pin_out);
    always_comb begin
        periph = '0;
        periph.spi_out = {8{lvl}};
        periph.wt_out = {12{lvl}};
        periph.ct_out = {5{lvl}};
        periph.dt_out = {4{lvl}};
        periph.cmp_out = {3{lvl}};
        periph.zc_out = {3{lvl}};
        case (kind)
            3'h1: periph.spi_en = {2{4'hD}};
            3'h2: periph.wt_en = '1;
            3'h3: periph.ct_en = '1;
            3'h4: periph.dt_en = '1;
            3'h5: periph.cmp_en = '1;
            3'h6: periph.zc_en = '1;
            default: periph.twi_low = '1;
        endcase
    end
endmodule : prm_far_model

// File: verification/testbench.sv
// Self-checking bench for the pin route block: bus access and routed pins.
// Assumes a 20 MHz clock and the far-side model for peripherals and pins.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [2:0] kind = 3'h0;
    logic lvl = 1'b0;
    logic [55:0] pin_in, pin_out, pin_oe_b, m;
    logic [31:0] q;
    logic [7:0] v;
    prm_pkg::prm_periph_t periph;
    prm_pkg::prm_return_t ret;
    int seed = 87593;
    int miscompares = 0;
    int n_tests = 0;
    localparam logic [11:0] ADR [7] = '{12'h014, 12'h010, 12'h018, 12'h01C, 12'h020,
        12'h024, 12'h028};
    localparam logic [7:0] MSK [7] = '{8'h0F, 8'h0F, 8'h3F, 8'h1F, 8'h07, 8'h07, 8'h07};
    always #25 clk = ~clk;
    prm_route_top dut (.SYS_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .PERIPH_IN(periph),
        .PERIPH_RET(ret), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_B(pin_oe_b));
    prm_far_model far (.kind(kind), .lvl(lvl), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .periph(periph), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Expected driven-pin mask for a group and its route value
    function automatic logic [55:0] emask(input int k, input logic [7:0] r);
        logic [55:0] e = '0;
        for (int i = 0; i < 5; i++) begin
            if (k == 1 && i < 2 && r[2*i+:2] != 2'h3) e |= 56'hD << prm_pkg::PRM_SPI_BASE[i][r[2*i+:2]];
            if (k == 0 && i < 2 && r[2*i+:2] != 2'h3)
                e |= (56'h3 << prm_pkg::PRM_TWI_HOST_BASE[i][r[2*i+:2]])
                    | (56'h3 << prm_pkg::PRM_TWI_DUAL_BASE[i][r[2*i+:2]]);
            if (k == 3) e |= 56'h1 << (r[i] ? prm_pkg::PRM_CT_ALT[i] : prm_pkg::PRM_CT_DEF[i]);
            if (k == 5 && i < 3) e |= 56'h1 << (r[i] ? prm_pkg::PRM_CMP_ALT : prm_pkg::PRM_CMP_DEF);
            if (k == 6 && i < 3) e |= 56'h1 << (r[i] ? prm_pkg::PRM_ZC_ALT : prm_pkg::PRM_ZC_DEF);
        end
        if (k == 2 && r[2:0] != 3'h7) e |= 56'h3F << (r[2:0] * 8);
        if (k == 2 && r[5:3] < 3'h4) e |= ((r[4:3] == 2'h1 || r[4:3] == 2'h2) ? 56'h7 : 56'h3F)
            << prm_pkg::PRM_WT1_BASE[r[4:3]];
        if (k == 4 && r[2:0] < 3'h4) e |= 56'hF << prm_pkg::PRM_DT_BASE[r[1:0]];
        return e;
    endfunction : emask
    // Expected data-in level seen by each serial unit
    function automatic logic [1:0] eret(input logic [7:0] r, input logic l);
        logic [55:0] pat = {7{8'hA5}} ^ {56{l}};
        for (int u = 0; u < 2; u++) begin
            eret[u] = (r[2*u+:2] == 2'h3) ? 1'b1 : pat[prm_pkg::PRM_SPI_BASE[u][r[2*u+:2]] + 1];
        end
    endfunction : eret
    task automatic chk(input logic [55:0] got, input logic [55:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One single AHB transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            ahb(1'b0, ADR[k], 32'h0);
            chk(56'({hresp, q}), 56'h0);
        end
        ahb(1'b1, 12'h000, 32'hFF);
        ahb(1'b0, 12'h000, 32'h0);
        chk(56'(q), 56'h0);
        for (int k = 0; k < 7; k++) begin
            for (int i = 0; i < 12; i++) begin
                v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
                kind <= 3'(k);
                lvl <= 1'($random(seed));
                ahb(1'b1, ADR[k], {24'h0, v});
                ahb(1'b0, ADR[k], 32'h0);
                chk(56'(q), 56'(v & MSK[k]));
                repeat (4) @(posedge clk);
                m = emask(k, v);
                chk(~pin_oe_b, m);
                chk(pin_out & m, (lvl && k != 0) ? m : 56'h0);
                if (k == 0) chk(56'(ret.twi_in),
                    56'({{4{v[3:2] == 2'h3}}, {4{v[1:0] == 2'h3}}}));
                if (k == 1) chk(56'({ret.spi_in[1][1], ret.spi_in[0][1]}), 56'(eret(v, lvl)));
            end
        end
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule : testbench
